/* File: common/cal_regs_pkg.sv */
`default_nettype none
// ----------------------------------------
// shared constants for the clamp, serializer and calibration bank
// ----------------------------------------
package cal_regs_pkg;
    localparam int ADDR_W     = 15;        // register address width on the serial port
    localparam int DATA_W     = 8;         // register data width
    localparam int FRAME_BITS = 1 + ADDR_W + DATA_W; // direction bit, address, data
    localparam int CNT_W      = 5;         // width of the serial bit counter

    typedef logic [ADDR_W-1:0] addr_t;     // register address
    typedef logic [DATA_W-1:0] byte_t;     // register byte
    typedef logic [CNT_W-1:0]  bitcnt_t;   // serial bit count

    localparam bitcnt_t ADDR_END  = bitcnt_t'(1 + ADDR_W);  // bits up to end of address
    localparam bitcnt_t FRAME_END = bitcnt_t'(FRAME_BITS);  // bits in a whole frame

    // ----------------------------------------
    // map
    // ----------------------------------------
    localparam addr_t CLAMP_ADDR    = 15'h0034; // input_clamp_control
    localparam byte_t CLAMP_RST     = 8'h2F;
    localparam int    CLAMP_EN_BIT  = 5;
    localparam addr_t SER_ADDR      = 15'h0040; // serializer_config
    localparam addr_t SER_RSV_FIRST = 15'h0041;
    localparam addr_t SER_LAST      = 15'h004F;
    localparam byte_t SER_RST       = 8'h04;
    localparam int    EMPH_W        = 4;        // emphasis field, bits 3..0
    localparam addr_t CAL_FIRST     = 15'h0050;
    localparam addr_t CAL_LAST      = 15'h01FF;
    localparam addr_t CAL_GAP_FIRST = 15'h006C; // start of the unnamed calibration tail
    localparam addr_t CFGA_ADDR     = 15'h0050; // calibration_config_a
    localparam byte_t CFGA_RST      = 8'h06;
    localparam int    SCAN_EN_BIT   = 4;
    localparam int    TRIG_BIT      = 3;
    localparam byte_t TRIG_MASK     = 8'h08;
    localparam addr_t SCAN_ADDR     = 15'h005A; // trim_scan_port
    localparam byte_t SCAN_RST      = 8'h00;
    localparam addr_t STAT_ADDR     = 15'h005B; // calibration_state
    localparam byte_t STAT_FIXED    = 8'h08;
    localparam int    STAT_IDLE_BIT = 1;

    // plain read/write bytes of the calibration region
    localparam int    NUM_PLAIN = 15;
    localparam addr_t PLAIN_ADDR [NUM_PLAIN] = '{15'h0051, 15'h0052, 15'h0053, 15'h0054,
        15'h0055, 15'h0056, 15'h0057, 15'h0058, 15'h0059, 15'h005C, 15'h005F, 15'h0066,
        15'h0067, 15'h006A, 15'h006B};
    localparam byte_t PLAIN_RST [NUM_PLAIN] = '{8'hF4, 8'h00, 8'h5C, 8'h1C, 8'h92, 8'h20,
        8'h10, 8'h00, 8'h00, 8'h00, 8'h00, 8'h02, 8'h01, 8'h00, 8'h20};

    // calibration engine
    localparam int CAL_CYCLES = 64;        // length of one foreground run
    localparam int SCAN_DEPTH = 16;        // trim vector bytes in the scan chain
    typedef enum {CAL_IDLE, CAL_INIT, CAL_RUN} cal_state_t;
endpackage
`default_nettype wire

/* File: logic/serial_port.sv */
`timescale 1ns/1ps
`default_nettype none
// ----------------------------------------
// serial register port: direction bit, address, then data, msb first
// ----------------------------------------
module serial_port (
    input  wire logic                 mclk,
    input  wire logic                 reset_n,
    input  wire logic                 sclk,
    input  wire logic                 chipSelN,
    input  wire logic                 sdi,
    input  wire cal_regs_pkg::byte_t  rdData,
    output logic                      wrStrobe,
    output logic                      rdStrobe,
    output cal_regs_pkg::addr_t       regAddr,
    output cal_regs_pkg::byte_t       wrData,
    output logic                      sdo,
    output logic                      sdoEn
);
    import cal_regs_pkg::*;

    logic                  sclkQ;      // sclk one cycle ago, for edge finding
    bitcnt_t               bitCntQ;    // bits taken in this frame
    logic [FRAME_BITS-1:0] shiftQ;     // incoming bits
    logic [FRAME_BITS-1:0] shiftD;
    logic                  readQ;      // frame is a read
    logic                  addrDoneQ;  // pulse: address complete
    logic                  wrPulseQ;   // pulse: write data complete
    byte_t                 outQ;       // outgoing read byte
    wire                   rise = sclk & ~sclkQ;
    wire                   fall = ~sclk & sclkQ;

    assign shiftD   = {shiftQ[FRAME_BITS-2:0], sdi};
    assign rdStrobe = addrDoneQ & readQ;
    assign wrStrobe = wrPulseQ;
    assign sdo      = outQ[DATA_W-1];
    // drive only during the data phase of a read
    assign sdoEn    = ~chipSelN & readQ & (bitCntQ >= ADDR_END);

    // shift in on rising sclk; bits past the frame end are ignored
    always_ff @(posedge mclk) begin
        if (!reset_n || chipSelN) begin
            bitCntQ   <= '0;
            shiftQ    <= '0;
            addrDoneQ <= 1'b0;
            wrPulseQ  <= 1'b0;
        end else begin
            addrDoneQ <= rise && (bitCntQ == ADDR_END - bitcnt_t'(1));
            wrPulseQ  <= rise && (bitCntQ == FRAME_END - bitcnt_t'(1)) && !readQ;
            if (rise && bitCntQ != FRAME_END) begin
                bitCntQ <= bitCntQ + bitcnt_t'(1);
                shiftQ  <= shiftD;
            end
        end
    end

    // address, direction and write data are held in flops
    always_ff @(posedge mclk) begin
        if (!reset_n) begin
            sclkQ   <= 1'b0;
            readQ   <= 1'b0;
            regAddr <= '0;
            wrData  <= '0;
        end else begin
            sclkQ <= sclk;
            if (rise && !chipSelN && bitCntQ == ADDR_END - bitcnt_t'(1)) begin
                regAddr <= shiftD[ADDR_W-1:0];
                readQ   <= shiftD[ADDR_W];
            end
            if (rise && !chipSelN && bitCntQ == FRAME_END - bitcnt_t'(1))
                wrData <= shiftD[DATA_W-1:0];
        end
    end

    // read byte loads on the strobe and moves out on falling sclk
    always_ff @(posedge mclk) begin
        if (!reset_n) begin
            outQ <= '0;
        end else if (rdStrobe) begin
            outQ <= rdData;
        end else if (fall && !chipSelN && bitCntQ > ADDR_END) begin
            outQ <= {outQ[DATA_W-2:0], 1'b0};
        end
    end
endmodule
`default_nettype wire

/* File: logic/cal_sequencer.sv */
`timescale 1ns/1ps
`default_nettype none
// ----------------------------------------
// foreground calibration sequencer and trim vector scan chain
// ----------------------------------------
module cal_sequencer #(
    parameter int DEPTH  = cal_regs_pkg::SCAN_DEPTH,
    parameter int CYCLES = cal_regs_pkg::CAL_CYCLES,
    localparam int IW    = $clog2(DEPTH),
    localparam int CW    = $clog2(CYCLES + 1)
) (
    input  wire logic                 mclk,
    input  wire logic                 reset_n,
    input  wire logic                 start,
    input  wire logic                 scanEn,
    input  wire logic                 scanRd,
    input  wire logic                 scanWr,
    input  wire cal_regs_pkg::byte_t  scanWrData,
    output cal_regs_pkg::byte_t       scanRdData,
    output logic                      busy,
    output logic [IW-1:0]             scanIndex
);
    import cal_regs_pkg::*;

    cal_state_t    stateQ;          // sequencer state
    logic [CW-1:0] cntQ;            // cycles left in the run
    byte_t         vecQ [DEPTH];    // trim vectors

    assign busy       = (stateQ != CAL_IDLE);
    assign scanRdData = vecQ[scanIndex];

    // a start from any state goes back through the initial state
    always_ff @(posedge mclk) begin
        if (!reset_n) begin
            stateQ <= CAL_IDLE;
            cntQ   <= '0;
        end else if (start) begin
            stateQ <= CAL_INIT;
            cntQ   <= '0;
        end else begin
            case (stateQ)
                CAL_INIT: begin
                    cntQ   <= CW'(CYCLES - 1);
                    stateQ <= CAL_RUN;
                end
                CAL_RUN: begin
                    if (cntQ == '0) stateQ <= CAL_IDLE;
                    else cntQ <= cntQ - CW'(1);
                end
                default: stateQ <= CAL_IDLE;
            endcase
        end
    end

    // each access moves to the next byte; leaving scan mode rewinds
    always_ff @(posedge mclk) begin
        if (!reset_n || !scanEn) begin
            scanIndex <= '0;
        end else if (scanRd || scanWr) begin
            scanIndex <= (scanIndex == IW'(DEPTH - 1)) ? '0 : scanIndex + IW'(1);
        end
    end

    // vector storage, written through the scan port only
    always_ff @(posedge mclk) begin
        if (!reset_n) begin
            for (int i = 0; i < DEPTH; i++) vecQ[i] <= '0;
        end else if (scanWr) begin
            vecQ[scanIndex] <= scanWrData;
        end
    end
endmodule
`default_nettype wire

/* File: logic/clamp_serializer_cal_regs.sv */
`timescale 1ns/1ps
`default_nettype none
// How it works
// - clamp bit five enables input clamp
// - four-bit emphasis field, upper bits zero
// - serializer group decoded 0x040 to 0x04F
// - calibration region 0x050 to 0x1FF mapped
// - scan enable opens the vector port
// - trigger bit starts calibration, self-clears
// - trigger returns sequencer to initial state
// - successive port accesses step through vectors
module clamp_serializer_cal_regs (
    input  wire logic                         mclk,
    input  wire logic                         reset_n,
    input  wire logic                         sclk,
    input  wire logic                         chipSelN,
    input  wire logic                         sdi,
    output logic                              sdo,
    output logic                              sdoEn,
    output logic                              inputClampOn,
    output logic [cal_regs_pkg::EMPH_W-1:0]   laneEmphasis,
    output logic                              calBusy,
    output logic                              scanEnable
);
    import cal_regs_pkg::*;

    // ----------------------------------------
    // local signals
    // ----------------------------------------
    localparam int IW = $clog2(SCAN_DEPTH);   // scan index width

    logic               wrStrobe;      // one cycle: write frame complete
    logic               rdStrobe;      // one cycle: read address complete
    addr_t              regAddr;       // address of the current frame
    byte_t              wrData;        // data of a completed write
    byte_t              rdData;        // byte returned on a read
    byte_t              clampQ;        // input_clamp_control contents
    logic [EMPH_W-1:0]  emphQ;         // serializer_config emphasis field
    byte_t              cfgAQ;         // calibration_config_a, trigger bit kept apart
    logic               trigQ;         // foreground_cal_trigger
    logic               trigD;
    byte_t              scanHoldQ;     // port byte seen while scan is off
    byte_t              plainQ [NUM_PLAIN]; // plain calibration bytes
    byte_t              scanRdData;    // current vector byte
    logic               scanRd;        // step the chain on a read
    logic               scanWr;        // load the chain on a write
    logic [IW-1:0]      scanIndex;     // position in the chain

    // ----------------------------------------
    // decode helpers
    // ----------------------------------------
    // address inside an inclusive window
    function automatic logic inRange(addr_t a, addr_t lo, addr_t hi);
        return (a >= lo) && (a <= hi);
    endfunction

    // write or read strobe aimed at one address
    function automatic logic hitAt(logic strobe, addr_t a, addr_t target);
        return strobe && (a == target);
    endfunction

    // ----------------------------------------
    // serial register port
    // ----------------------------------------
    serial_port u_port (
        .mclk     (mclk),
        .reset_n  (reset_n),
        .sclk     (sclk),
        .chipSelN (chipSelN),
        .sdi      (sdi),
        .rdData   (rdData),
        .wrStrobe (wrStrobe),
        .rdStrobe (rdStrobe),
        .regAddr  (regAddr),
        .wrData   (wrData),
        .sdo      (sdo),
        .sdoEn    (sdoEn)
    );

    // ----------------------------------------
    // clamp and serializer registers
    // ----------------------------------------
    // clamp byte is fully writable; only bit five steers the front end
    always_ff @(posedge mclk) begin
        if (!reset_n) begin
            clampQ <= CLAMP_RST;
        end else if (hitAt(wrStrobe, regAddr, CLAMP_ADDR)) begin
            clampQ <= wrData;
        end
    end

    assign inputClampOn = clampQ[CLAMP_EN_BIT];

    // only the emphasis field has storage; upper bits are dropped
    always_ff @(posedge mclk) begin
        if (!reset_n) begin
            emphQ <= SER_RST[EMPH_W-1:0];
        end else if (hitAt(wrStrobe, regAddr, SER_ADDR)) begin
            emphQ <= wrData[EMPH_W-1:0];
        end
    end

    assign laneEmphasis = emphQ;

    // ----------------------------------------
    // calibration configuration
    // ----------------------------------------
    // the trigger is stored apart so the stored byte never holds it
    always_ff @(posedge mclk) begin
        if (!reset_n) begin
            cfgAQ <= CFGA_RST;
        end else if (hitAt(wrStrobe, regAddr, CFGA_ADDR)) begin
            cfgAQ <= wrData & ~TRIG_MASK;
        end
    end

    assign scanEnable = cfgAQ[SCAN_EN_BIT];

    // a written one lives exactly one cycle; the sequencer takes it
    // in that cycle, so the bit has already read back as zero by the
    // time any following frame could sample it
    // self-clearing trigger
    assign trigD = hitAt(wrStrobe, regAddr, CFGA_ADDR) && wrData[TRIG_BIT];

    always_ff @(posedge mclk) begin
        if (!reset_n) trigQ <= 1'b0;
        else trigQ <= trigD;
    end

    // the fifteen PLAIN_ADDR calibration bytes are plain storage
    for (genvar i = 0; i < NUM_PLAIN; i++) begin : g_plain
        always_ff @(posedge mclk) begin
            if (!reset_n) begin
                plainQ[i] <= PLAIN_RST[i];
            end else if (hitAt(wrStrobe, regAddr, PLAIN_ADDR[i])) begin
                plainQ[i] <= wrData;
            end
        end
    end

    // ----------------------------------------
    // scan port
    // ----------------------------------------
    // step per access
    assign scanRd = hitAt(rdStrobe, regAddr, SCAN_ADDR) && scanEnable;
    assign scanWr = hitAt(wrStrobe, regAddr, SCAN_ADDR) && scanEnable;

    // with scan off the port behaves as a plain byte
    always_ff @(posedge mclk) begin
        if (!reset_n) begin
            scanHoldQ <= SCAN_RST;
        end else if (hitAt(wrStrobe, regAddr, SCAN_ADDR) && !scanEnable) begin
            scanHoldQ <= wrData;
        end
    end

    // ----------------------------------------
    // calibration sequencer
    // ----------------------------------------
    // settings are not resynchronised into the engine: the host must
    // finish all setup before the trigger, and must toggle the serial
    // link output enable afterwards since the restart can upset it
    // trigger restarts sequencer
    cal_sequencer #(
        .DEPTH  (SCAN_DEPTH),
        .CYCLES (CAL_CYCLES)
    ) u_seq (
        .mclk       (mclk),
        .reset_n    (reset_n),
        .start      (trigQ),
        .scanEn     (scanEnable),
        .scanRd     (scanRd),
        .scanWr     (scanWr),
        .scanWrData (wrData),
        .scanRdData (scanRdData),
        .busy       (calBusy),
        .scanIndex  (scanIndex)
    );

    // ----------------------------------------
    // read mux
    // ----------------------------------------
    // unmapped and undefined addresses read as zero
    always_comb begin
        rdData = '0;
        if (regAddr == CLAMP_ADDR) begin
            rdData = clampQ;
        end else if (inRange(regAddr, SER_ADDR, SER_LAST)) begin
            if (regAddr == SER_ADDR) rdData = byte_t'(emphQ);
        end else if (inRange(regAddr, CAL_FIRST, CAL_LAST)) begin
            if (regAddr == CFGA_ADDR) begin
                rdData = cfgAQ | (trigQ ? TRIG_MASK : '0);
            end else if (regAddr == SCAN_ADDR) begin
                rdData = scanEnable ? scanRdData : scanHoldQ;
            end else if (regAddr == STAT_ADDR) begin
                rdData = STAT_FIXED;
                rdData[STAT_IDLE_BIT] = ~calBusy;
            end else begin
                for (int i = 0; i < NUM_PLAIN; i++) begin
                    if (regAddr == PLAIN_ADDR[i]) rdData = plainQ[i];
                end
            end
        end
    end

    // ----------------------------------------
    // assertions
    // ----------------------------------------
    localparam int CAL_BOUND = CAL_CYCLES + 4;  // bound on a busy stretch, which lasts CAL_CYCLES + 1

    default clocking cb @(posedge mclk); endclocking
    default disable iff (!reset_n);

    logic             clampBitIn;  // clamp bit of the write data
    logic [EMPH_W-1:0] emphIn;     // emphasis field of the write data
    assign clampBitIn = wrData[CLAMP_EN_BIT];
    assign emphIn     = wrData[EMPH_W-1:0];

    // a write of one to the trigger
    sequence trigWrite_s;
        hitAt(wrStrobe, regAddr, CFGA_ADDR) && wrData[TRIG_BIT];
    endsequence

    // the trigger stands for one cycle then drops
    sequence trigPulse_s;
        trigQ ##1 !trigQ;
    endsequence

    // the sequencer leaves idle and stays busy through init
    sequence restart_s;
        calBusy [*2];
    endsequence

    clampReset_a: assert property ($rose(reset_n) |-> inputClampOn)
        else $error("clamp not enabled after reset");

    clampWrite_a: assert property (hitAt(wrStrobe, regAddr, CLAMP_ADDR)
        |=> inputClampOn == $past(clampBitIn))
        else $error("clamp enable did not follow write");

    emphWrite_a: assert property (hitAt(wrStrobe, regAddr, SER_ADDR)
        |=> laneEmphasis == $past(emphIn))
        else $error("emphasis did not follow write");

    serRead_a: assert property (hitAt(rdStrobe, regAddr, SER_ADDR)
        |-> rdData == byte_t'(laneEmphasis))
        else $error("serializer readback wrong or upper bits set");

    serReserved_a: assert property (rdStrobe && inRange(regAddr, SER_RSV_FIRST, SER_LAST)
        |-> rdData == '0)
        else $error("reserved serializer address not zero");

    calTail_a: assert property (rdStrobe && inRange(regAddr, CAL_GAP_FIRST, CAL_LAST)
        |-> rdData == '0)
        else $error("reserved calibration address not zero");

    scanGate_a: assert property (hitAt(rdStrobe, regAddr, SCAN_ADDR) && !scanEnable
        |=> scanIndex == '0)
        else $error("scan chain moved while disabled");

    scanStep_a: assert property (scanRd || scanWr
        |=> scanIndex == IW'($past(scanIndex) + 1))
        else $error("scan index did not step");

    trigClear_a: assert property (trigWrite_s |=> trigPulse_s)
        else $error("trigger did not self clear");

    calRestart_a: assert property (trigQ |=> restart_s)
        else $error("trigger did not restart sequencer");

    calFinish_a: assert property ($rose(calBusy) |-> ##[1:CAL_BOUND] !calBusy)
        else $error("calibration run did not finish");

    trigRead_a: assert property (hitAt(rdStrobe, regAddr, CFGA_ADDR)
        |-> rdData[TRIG_BIT] == trigQ)
        else $error("trigger readback wrong");

    statRead_a: assert property (hitAt(rdStrobe, regAddr, STAT_ADDR)
        |-> rdData[STAT_IDLE_BIT] == !calBusy)
        else $error("status idle bit wrong");
endmodule
`default_nettype wire

/* File: sim/host_model.sv */
`timescale 1ns/1ps
`default_nettype none
// ------------------------------
// host side of the serial port
// ------------------------------
module host_model (
    input  wire logic mclk,
    input  wire logic sdo,
    output logic      sclk,
    output logic      chipSelN,
    output logic      sdi
);
    import cal_regs_pkg::*;
    initial begin
        sclk = 1'b0;
        chipSelN = 1'b1;
        sdi = 1'b0;
    end
    // step n edges, then move off the edge
    task automatic step(input int n);
        repeat (n) @(posedge mclk);
        #2;
    endtask
    // one whole frame; four mclk per sclk phase leaves margin over three
    task automatic xfer(input logic rd, input addr_t a, input byte_t d, output byte_t q);
        logic [FRAME_BITS-1:0] fr;
        fr = {rd, a, d};
        q = 8'h00;
        chipSelN = 1'b0;
        for (int i = 0; i < FRAME_BITS; i++) begin
            sdi = fr[FRAME_BITS-1-i];
            step(4);
            // read bits are taken just before each data rise
            if (i > ADDR_W) begin
                q = {q[DATA_W-2:0], sdo};
            end
            sclk = 1'b1;
            step(4);
            sclk = 1'b0;
        end
        step(2);
        chipSelN = 1'b1;
        sdi = ~sdi;  // released line must not look like held data
        step(2);
    endtask
endmodule
`default_nettype wire

/* File: sim/tb.sv */
`timescale 1ns/1ps
`default_nettype none
module tb;
    import cal_regs_pkg::*;
    logic              mclk;
    logic              reset_n;
    logic              sclk;
    logic              chipSelN;
    logic              sdi;
    logic              sdo;
    logic              sdoEn;
    logic              inputClampOn;
    logic              calBusy;
    logic              scanEnable;
    logic [EMPH_W-1:0] laneEmphasis;
    int                error_cnt;
    int                checks_done;
    int                busyCnt = 0; // cycles seen with calBusy high
    int                enCnt = 0;   // cycles seen with sdoEn high
    byte_t             q;
    clamp_serializer_cal_regs clamp_serializer_cal_regs_inst (
        .mclk(mclk), .reset_n(reset_n), .sclk(sclk), .chipSelN(chipSelN),
        .sdi(sdi), .sdo(sdo), .sdoEn(sdoEn), .inputClampOn(inputClampOn),
        .laneEmphasis(laneEmphasis), .calBusy(calBusy), .scanEnable(scanEnable));
    host_model host_model_inst (
        .mclk(mclk), .sdo(sdo), .sclk(sclk), .chipSelN(chipSelN), .sdi(sdi));
    // ------------------------------
    // clock, busy counter, shared tasks
    // ------------------------------
    initial begin
        mclk = 1'b0;
        forever #25 mclk = ~mclk;
    end
    always @(posedge mclk) begin
        if (calBusy === 1'b1) begin
            busyCnt <= busyCnt + 1;
        end
        if (sdoEn === 1'b1) begin
            enCnt <= enCnt + 1;
        end
    end
    task automatic end_sim;
        if (error_cnt == 0 && checks_done > 0) begin
            $display("No errors found");
        end else begin
            $display("Errors were found");
        end
        $finish;
    endtask
    task automatic check(input byte_t seen, input byte_t exp);
        checks_done++;
        if (seen !== exp) begin
            error_cnt++;
            $display("MISMATCH at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask
    task automatic wr(input addr_t a, input byte_t d);
        host_model_inst.xfer(1'b0, a, d, q);
    endtask
    task automatic rdc(input addr_t a, input byte_t exp);
        host_model_inst.xfer(1'b1, a, 8'h00, q);
        check(q, exp);
    endtask
    // watchdog: the sequence needs well under half this span
    initial begin
        #2000000;
        error_cnt++;
        end_sim;
    end
    // ------------------------------
    // main sequence
    // ------------------------------
    initial begin
        reset_n = 1'b0;
        error_cnt = 0;
        checks_done = 0;
        repeat (10) @(posedge mclk);
        #2;
        reset_n = 1'b1;
        check(byte_t'(inputClampOn), 8'h01);
        check(byte_t'(laneEmphasis), SER_RST);
        check(byte_t'(sdoEn), 8'h00);
        rdc(CLAMP_ADDR, CLAMP_RST);
        // one read drives sdo from its 16th rise until deselect: 69 edges here
        check(byte_t'(enCnt), 8'h45);
        rdc(SER_ADDR, SER_RST);
        rdc(CFGA_ADDR, CFGA_RST);
        // clamp bit off then on again
        wr(CLAMP_ADDR, 8'hDF);
        check(byte_t'(inputClampOn), 8'h00);
        wr(CLAMP_ADDR, 8'h20);
        rdc(CLAMP_ADDR, 8'h20);
        check(byte_t'(inputClampOn), 8'h01);
        // emphasis keeps only the low nibble
        wr(SER_ADDR, 8'hFF);
        check(byte_t'(laneEmphasis), 8'h0F);
        rdc(SER_ADDR, 8'h0F);
        wr(SER_LAST, 8'h55);
        rdc(SER_LAST, 8'h00);
        rdc(SER_RSV_FIRST, 8'h00);
        // calibration region resets, unnamed tail, one plain byte
        for (int i = 0; i < NUM_PLAIN; i++) begin
            rdc(PLAIN_ADDR[i], PLAIN_RST[i]);
        end
        wr(CAL_GAP_FIRST, 8'hAA);
        rdc(CAL_GAP_FIRST, 8'h00);
        rdc(CAL_LAST, 8'h00);
        wr(15'h0058, 8'h06);
        rdc(15'h0058, 8'h06);
        wr(15'h0051, 8'h04);
        // nothing has been busy yet, so the counter still starts at zero
        wr(CFGA_ADDR, 8'h0E);
        check(byte_t'(calBusy), 8'h01);
        // link enable toggle sits outside this bank
        rdc(CFGA_ADDR, CFGA_RST);
        check(byte_t'(busyCnt), byte_t'(CAL_CYCLES + 1));
        rdc(STAT_ADDR, STAT_FIXED | 8'h02);
        // scan chain: load two bytes, rewind, read them back
        wr(CFGA_ADDR, 8'h10);
        check(byte_t'(scanEnable), 8'h01);
        wr(SCAN_ADDR, 8'hA5);
        wr(SCAN_ADDR, 8'h3C);
        wr(CFGA_ADDR, 8'h00);
        wr(CFGA_ADDR, 8'h10);
        rdc(SCAN_ADDR, 8'hA5);
        rdc(SCAN_ADDR, 8'h3C);
        rdc(SCAN_ADDR, 8'h00);
        // scan off: the port is a plain byte again
        wr(CFGA_ADDR, 8'h00);
        wr(SCAN_ADDR, 8'h77);
        rdc(SCAN_ADDR, 8'h77);
        end_sim;
    end
endmodule
`default_nettype wire
